// ==== peak_level_pkg.sv ====
// Constants, register map and carriers for the peak and level detector.
// Assumes a 16-bit register address port with 32-bit data words.
package peak_level_pkg;

  // Register addresses
  localparam logic [15:0] ADDR_CUR_PEAK   = 16'he500; // current_peak_record
  localparam logic [15:0] ADDR_VOLT_PEAK  = 16'he501; // voltage_peak_record
  localparam logic [15:0] ADDR_OVERCUR    = 16'he507; // overcurrent_threshold
  localparam logic [15:0] ADDR_OVERVOLT   = 16'he508; // overvoltage_threshold
  localparam logic [15:0] ADDR_SAG        = 16'he509; // sag_threshold
  localparam logic [15:0] ADDR_EVT_STATUS = 16'he5f0; // event_status_reg
  localparam logic [15:0] ADDR_EVT_ENABLE = 16'he5f1; // event_enable_reg
  localparam logic [15:0] ADDR_PH_STATUS  = 16'he600; // phase_status_reg
  localparam logic [15:0] ADDR_MODE       = 16'he700; // measurement_mode_reg
  localparam logic [15:0] ADDR_PEAK_WIN   = 16'he703; // peak_window_halfcycles

  // Field positions
  localparam int SEL_LO       = 2;  // peak_phase_select low bit
  localparam int PEAK_PH_LO   = 24; // peak phase indicator low bit
  localparam int BIT_OVERCUR  = 17; // imax_exceeded_flag
  localparam int BIT_OVERVOLT = 18; // vmax_exceeded_flag
  localparam int BIT_CUR_DONE = 23; // current_peak_done_flag
  localparam int BIT_VOLT_DONE = 24; // voltage_peak_done_flag
  localparam int IMAX_PH_LO   = 3;  // imax_phase_bits low bit
  localparam int VMAX_PH_LO   = 9;  // vmax_phase_bits low bit

  // Levels
  localparam logic [23:0] FULL_SCALE   = 24'h512d40;  // Largest magnitude
  localparam logic [23:0] SAG_ZERO_MAX = 24'h000001;  // Acts as zero level

  // Reset values
  localparam logic [23:0] RST_LEVEL    = FULL_SCALE;  // No level events
  localparam logic [23:0] RST_SAG      = 24'h000000;
  localparam logic [7:0]  RST_MODE     = 8'h00;
  localparam logic [7:0]  RST_PEAK_WIN = 8'h00;

  // One set of per-phase samples
  typedef struct packed {
    logic              valid;  // New samples this cycle
    logic [2:0][23:0]  volt;   // Signed high-pass outputs, phase C..A
    logic [2:0][23:0]  cur;    // Signed current samples, phase C..A
  } samples_s;

  // Register port request
  typedef struct packed {
    logic        wr;     // Write strobe
    logic        rd;     // Read strobe
    logic [15:0] addr;   // Register address
    logic [31:0] wdata;  // Write data
  } reg_req_s;

  // Magnitude of a signed 24-bit sample
  function automatic logic [23:0] magnitude(input logic [23:0] s);
    magnitude = s[23] ? 24'(-s) : s;
  endfunction : magnitude

endpackage : peak_level_pkg

// ==== peak_level_detector.sv ====
// Peak tracking, overvoltage, overcurrent and sag comparison logic.
// Assumes samples and zero-crossing pulses arrive on mclk.
`timescale 1ns/100ps
module peak_level_detector
  import peak_level_pkg::*;
#(
  parameter int PHASES = 3  // Number of line phases
) (
  // Clock and reset
  input  wire logic                      mclk,
  input  wire logic                      rst,
  // Register port
  input  wire peak_level_pkg::reg_req_s  req,
  output logic [31:0]                    rdata,
  // Sample stream and zero crossings
  input  wire peak_level_pkg::samples_s  smp,
  input  wire logic [PHASES-1:0]         zero_cross,
  // Event outputs
  output logic                           event_irq_n,
  output logic [PHASES-1:0]              sag_below
);
  import peak_level_pkg::*;

  // Software registers
  logic [23:0]       overcur_thr_ff;   // overcurrent_threshold
  logic [23:0]       overvolt_thr_ff;  // overvoltage_threshold
  logic [23:0]       sag_thr_ff;       // sag_threshold
  logic [7:0]        mode_ff;          // measurement_mode_reg
  logic [7:0]        peak_win_ff;      // peak_window_halfcycles
  logic [31:0]       enable_ff;        // event_enable_reg
  // Status and records
  logic [31:0]       status_ff;        // event_status_reg
  logic [15:0]       phstat_ff;        // phase_status_reg
  logic [31:0]       cur_rec_ff;       // current_peak_record
  logic [31:0]       volt_rec_ff;      // voltage_peak_record
  // Window tracking
  logic [8:0]        zc_cnt_ff;        // Half cycles seen in window
  logic [23:0]       cur_max_ff;       // Running current maximum
  logic [23:0]       volt_max_ff;      // Running voltage maximum
  logic [PHASES-1:0] cur_ph_ff;        // Phase of running current max
  logic [PHASES-1:0] volt_ph_ff;       // Phase of running voltage max
  // Output flops
  logic [31:0]       rdata_ff;
  logic              irq_n_ff;
  logic [PHASES-1:0] sag_ff;

  // Decoded strokes
  logic              wr_status;        // Write to status register
  logic              wr_win;           // Write to window length
  logic [PHASES-1:0] sel;              // Enabled peak phases
  logic [1:0]        zc_inc;           // Enabled crossings this cycle
  logic [8:0]        nxt_zc_cnt;       // Count including this cycle
  logic              win_end;          // Window closes this cycle
  logic [23:0]       nxt_cur_max;
  logic [23:0]       nxt_volt_max;
  logic [PHASES-1:0] nxt_cur_ph;
  logic [PHASES-1:0] nxt_volt_ph;
  logic [PHASES-1:0] ov_hit;           // Overvoltage per phase
  logic [PHASES-1:0] oc_hit;           // Overcurrent per phase
  logic [PHASES-1:0] nxt_sag;
  logic [31:0]       set_mask;         // Status bits raised now
  logic [31:0]       clr_mask;         // Status bits written with one

  assign wr_status = req.wr && (req.addr == ADDR_EVT_STATUS);
  assign wr_win    = req.wr && (req.addr == ADDR_PEAK_WIN);
  assign sel       = mode_ff[SEL_LO +: PHASES];

  // Crossing count and window end
  always_comb begin
    zc_inc = 2'h0;
    for (int p = 0; p < PHASES; p++) begin
      zc_inc = zc_inc + 2'(zero_cross[p] & sel[p]);
    end
    nxt_zc_cnt = zc_cnt_ff + 9'(zc_inc);
    win_end    = (peak_win_ff != 8'h00) &&
                 (nxt_zc_cnt >= {1'b0, peak_win_ff});
  end

  // Running maxima and level comparisons per phase
  always_comb begin
    nxt_cur_max  = cur_max_ff;
    nxt_volt_max = volt_max_ff;
    nxt_cur_ph   = cur_ph_ff;
    nxt_volt_ph  = volt_ph_ff;
    ov_hit       = '0;
    oc_hit       = '0;
    nxt_sag      = sag_ff;
    if (smp.valid) begin
      for (int p = 0; p < PHASES; p++) begin
        // Peak candidates on enabled phases
        if (sel[p] && magnitude(smp.cur[p]) > nxt_cur_max) begin
          nxt_cur_max = magnitude(smp.cur[p]);
          nxt_cur_ph  = PHASES'(1) << p;
        end
        if (sel[p] && magnitude(smp.volt[p]) > nxt_volt_max) begin
          nxt_volt_max = magnitude(smp.volt[p]);
          nxt_volt_ph  = PHASES'(1) << p;
        end
        // Level events; zero threshold always fires
        ov_hit[p] = (overvolt_thr_ff == 24'h000000) ||
                    (magnitude(smp.volt[p]) > overvolt_thr_ff);
        oc_hit[p] = (overcur_thr_ff == 24'h000000) ||
                    (magnitude(smp.cur[p]) > overcur_thr_ff);
        // Sag comparison; threshold of zero or one never sags
        nxt_sag[p] = (sag_thr_ff > SAG_ZERO_MAX) &&
                     (magnitude(smp.volt[p]) <= sag_thr_ff);
      end
    end
  end

  // Status set and clear masks
  always_comb begin
    set_mask = '0;
    set_mask[BIT_CUR_DONE]  = win_end;
    set_mask[BIT_VOLT_DONE] = win_end;
    set_mask[BIT_OVERVOLT]  = |ov_hit;
    set_mask[BIT_OVERCUR]   = |oc_hit;
    clr_mask = wr_status ? req.wdata : 32'h0;
  end

  // Software registers written over the port
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      overcur_thr_ff  <= RST_LEVEL;
      overvolt_thr_ff <= RST_LEVEL;
      sag_thr_ff      <= RST_SAG;
      mode_ff         <= RST_MODE;
      peak_win_ff     <= RST_PEAK_WIN;
      enable_ff       <= 32'h0;
    end else if (req.wr) begin
      if (req.addr == ADDR_OVERCUR) begin
        overcur_thr_ff <= req.wdata[23:0];
      end else if (req.addr == ADDR_OVERVOLT) begin
        overvolt_thr_ff <= req.wdata[23:0];
      end else if (req.addr == ADDR_SAG) begin
        sag_thr_ff <= req.wdata[23:0];
      end else if (req.addr == ADDR_MODE) begin
        mode_ff <= req.wdata[7:0];
      end else if (req.addr == ADDR_PEAK_WIN) begin
        peak_win_ff <= req.wdata[7:0];
      end else if (req.addr == ADDR_EVT_ENABLE) begin
        enable_ff <= req.wdata;
      end
    end
  end

  // Window counter, restarted at window ends and on window-length writes
  // A zero length never ends a window; the count may then wrap
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      zc_cnt_ff <= 9'h0;
    end else if (wr_win || win_end) begin
      zc_cnt_ff <= 9'h0;
    end else begin
      zc_cnt_ff <= nxt_zc_cnt;
    end
  end

  // Running maxima restart each window
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cur_max_ff  <= 24'h0;
      volt_max_ff <= 24'h0;
      cur_ph_ff   <= '0;
      volt_ph_ff  <= '0;
    end else if (win_end || wr_win) begin
      cur_max_ff  <= 24'h0;
      volt_max_ff <= 24'h0;
      cur_ph_ff   <= '0;
      volt_ph_ff  <= '0;
    end else begin
      cur_max_ff  <= nxt_cur_max;
      volt_max_ff <= nxt_volt_max;
      cur_ph_ff   <= nxt_cur_ph;
      volt_ph_ff  <= nxt_volt_ph;
    end
  end

  // Peak records load only at window end
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cur_rec_ff  <= 32'h0;
      volt_rec_ff <= 32'h0;
    end else if (win_end) begin
      cur_rec_ff  <= 32'h0;
      volt_rec_ff <= 32'h0;
      cur_rec_ff[23:0]  <= nxt_cur_max;
      volt_rec_ff[23:0] <= nxt_volt_max;
      cur_rec_ff[PEAK_PH_LO +: PHASES]  <= nxt_cur_ph;
      volt_rec_ff[PEAK_PH_LO +: PHASES] <= nxt_volt_ph;
    end
  end

  // Sticky event flags; a new event beats a clear
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      status_ff <= 32'h0;
    end else begin
      status_ff <= (status_ff & ~clr_mask) | set_mask;
    end
  end

  // Per-phase level bits, cleared with their summary flag
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      phstat_ff <= 16'h0;
    end else begin
      if (clr_mask[BIT_OVERVOLT]) begin
        phstat_ff[VMAX_PH_LO +: PHASES] <= ov_hit;
      end else begin
        phstat_ff[VMAX_PH_LO +: PHASES] <=
          phstat_ff[VMAX_PH_LO +: PHASES] | ov_hit;
      end
      if (clr_mask[BIT_OVERCUR]) begin
        phstat_ff[IMAX_PH_LO +: PHASES] <= oc_hit;
      end else begin
        phstat_ff[IMAX_PH_LO +: PHASES] <=
          phstat_ff[IMAX_PH_LO +: PHASES] | oc_hit;
      end
    end
  end

  // Interrupt follows enabled flags
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      irq_n_ff <= 1'b1;
    end else begin
      // Next status is used, so the pin moves with its flag
      irq_n_ff <=
        ~|(((status_ff & ~clr_mask) | set_mask) & enable_ff);
    end
  end

  // Sag comparison result, held between samples
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      sag_ff <= '0;
    end else begin
      sag_ff <= nxt_sag;
    end
  end

  // Read data, one cycle after the read strobe
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rdata_ff <= 32'h0;
    end else if (req.rd) begin
      if (req.addr == ADDR_CUR_PEAK) begin
        rdata_ff <= cur_rec_ff;
      end else if (req.addr == ADDR_VOLT_PEAK) begin
        rdata_ff <= volt_rec_ff;
      end else if (req.addr == ADDR_OVERCUR) begin
        rdata_ff <= {8'h00, overcur_thr_ff};
      end else if (req.addr == ADDR_OVERVOLT) begin
        rdata_ff <= {8'h00, overvolt_thr_ff};
      end else if (req.addr == ADDR_SAG) begin
        rdata_ff <= {8'h00, sag_thr_ff};
      end else if (req.addr == ADDR_EVT_STATUS) begin
        rdata_ff <= status_ff;
      end else if (req.addr == ADDR_EVT_ENABLE) begin
        rdata_ff <= enable_ff;
      end else if (req.addr == ADDR_PH_STATUS) begin
        rdata_ff <= {16'h0, phstat_ff};
      end else if (req.addr == ADDR_MODE) begin
        rdata_ff <= {24'h0, mode_ff};
      end else if (req.addr == ADDR_PEAK_WIN) begin
        rdata_ff <= {24'h0, peak_win_ff};
      end else begin
        rdata_ff <= 32'h0; // Unmapped reads as zero
      end
    end
  end

  assign rdata       = rdata_ff;
  assign event_irq_n = irq_n_ff;
  assign sag_below   = sag_ff;

endmodule : peak_level_detector

// ==== peak_level_monitor.sv ====
// Port checker for the peak and level detector.
// Assumes it is bound onto every peak_level_detector instance.
`timescale 1ns/100ps
module peak_level_monitor
  import peak_level_pkg::*;
#(
  parameter int PHASES = 3  // Number of line phases
) (
  // Clock and reset
  input wire logic                      mclk,
  input wire logic                      rst,
  // Register port
  input wire peak_level_pkg::reg_req_s  req,
  input wire logic [31:0]               rdata,
  // Samples and events
  input wire peak_level_pkg::samples_s  smp,
  input wire logic [PHASES-1:0]         zero_cross,
  input wire logic                      event_irq_n,
  input wire logic [PHASES-1:0]         sag_below
);
  import peak_level_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // Reads of the 24-bit levels
  sequence s_thr_rd;
    req.rd && (req.addr == ADDR_OVERCUR || req.addr == ADDR_OVERVOLT
      || req.addr == ADDR_SAG);
  endsequence
  // Reads of either peak record
  sequence s_pk_rd;
    req.rd && (req.addr == ADDR_CUR_PEAK || req.addr == ADDR_VOLT_PEAK);
  endsequence
  property p_thr_top; s_thr_rd |=> rdata[31:24] == 8'h00; endproperty
  a_thr_top: assert property (p_thr_top)
    else $error("level read top byte not zero");
  property p_pk_fmt;
    s_pk_rd |=> $onehot0(rdata[26:24]) && rdata[31:27] == 5'h00;
  endproperty
  a_pk_fmt: assert property (p_pk_fmt)
    else $error("peak record phase field malformed");
  property p_rd_hold; !req.rd |=> $stable(rdata); endproperty
  a_rd_hold: assert property (p_rd_hold)
    else $error("read data moved without a read");
  property p_sag_hold; !smp.valid |=> $stable(sag_below); endproperty
  a_sag_hold: assert property (p_sag_hold)
    else $error("sag flags moved without a sample");
  property p_irq_rise;
    $rose(event_irq_n) |-> $past(req.wr) || $past(req.wr, 2);
  endproperty
  a_irq_rise: assert property (p_irq_rise)
    else $error("interrupt released without a write");
  property p_irq_fall;
    $fell(event_irq_n) |-> $past(smp.valid || |zero_cross || req.wr)
      || $past(smp.valid || |zero_cross || req.wr, 2);
  endproperty
  a_irq_fall: assert property (p_irq_fall)
    else $error("interrupt asserted without a cause");
  property p_unmapped; req.rd && req.addr == 16'h0000 |=> rdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  property p_byte_rd;
    req.rd && (req.addr == ADDR_MODE || req.addr == ADDR_PEAK_WIN)
      |=> rdata[31:8] == 24'h0;
  endproperty
  a_byte_rd: assert property (p_byte_rd)
    else $error("byte register read upper bits set");
endmodule : peak_level_monitor

bind peak_level_detector peak_level_monitor #(.PHASES(PHASES)) u_mon (
  .mclk(mclk), .rst(rst), .req(req), .rdata(rdata), .smp(smp),
  .zero_cross(zero_cross), .event_irq_n(event_irq_n),
  .sag_below(sag_below));

// ==== host_model.sv ====
// Host model issuing single-cycle register reads and writes.
// Assumes the bench calls its tasks by hierarchical name.
`timescale 1ns/100ps
module host_model
  import peak_level_pkg::*;
(
  // Clock
  input  wire logic                 mclk,
  // Register request
  output peak_level_pkg::reg_req_s  req
);
  import peak_level_pkg::*;
  initial req = '0;
  // One strobe held across one edge, then bus scrambled
  task automatic xfer(input logic w, input logic [15:0] a,
                      input logic [31:0] d);
    @(posedge mclk);
    #1;
    req = '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge mclk);
    #1;
    req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask : xfer
  // Write, used to clear flags by writing one
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr
  // Read, one register address per call
  task automatic rd(input logic [15:0] a);
    xfer(1'b0, a, 32'h0);
  endtask : rd
endmodule : host_model

// ==== tb_peak_and_level_event_detector.sv ====
// Self-checking bench for the peak and level detector.
// Assumes host_model and the bound checker are compiled first.
`timescale 1ns/100ps
module tb_peak_and_level_event_detector;
  import peak_level_pkg::*;
  logic mclk, rst, event_irq_n, rd_pend;
  reg_req_s    req;
  samples_s    smp;
  logic [31:0] rdata, exp_q[$];
  logic [2:0]  zero_cross, sag_below;
  logic [23:0] r;
  int          err_total, cmp_count, cyc;
  peak_level_detector #(.PHASES(3)) u_dut (.mclk(mclk), .rst(rst),
    .req(req), .rdata(rdata), .smp(smp), .zero_cross(zero_cross),
    .event_irq_n(event_irq_n), .sag_below(sag_below));
  host_model u_host (.mclk(mclk), .req(req));
  always #2 mclk = ~mclk;
  // Shared compare body; counts and reports
  task automatic chk(input string n, input logic [31:0] e, g);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // Read data against its oldest note
  task automatic chk_rd(input logic [31:0] e, g);
    chk("rdata", e, g);
  endtask : chk_rd
  // Interrupt pin level
  task automatic chk_irq(input logic e);
    chk("event_irq_n", 32'(e), 32'(event_irq_n));
  endtask : chk_irq
  // Sag flags, one per phase
  task automatic chk_sag(input logic [2:0] e);
    chk("sag_below", 32'(e), 32'(sag_below));
  endtask : chk_sag
  // Read with its expected value noted
  task automatic rdc(input logic [15:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    u_host.rd(a);
  endtask : rdc
  // Result watcher for read data
  always @(posedge mclk) begin
    #2;
    if (rd_pend) chk_rd(exp_q.pop_front(), rdata);
    rd_pend = req.rd;
  end
  task automatic settle;
    repeat (3) @(posedge mclk);
    #1;
  endtask : settle
  task automatic samp(input logic [2:0][23:0] v, c);
    @(posedge mclk);
    #1;
    smp = '{valid: 1'b1, volt: v, cur: c};
    @(posedge mclk);
    #1;
    smp = '{valid: 1'b0, volt: ~v, cur: ~c};
  endtask : samp
  task automatic zc(input logic [2:0] m);
    @(posedge mclk);
    #1;
    zero_cross = m;
    @(posedge mclk);
    #1;
    zero_cross = 3'h0;
  endtask : zc
  // One level event on one phase, then cleared
  task automatic lvl(input int cur, input int ph, input logic [23:0] mag);
    logic [2:0][23:0] s;
    int b, pb;
    s = '0;
    s[ph] = -mag;
    b = cur ? BIT_OVERCUR : BIT_OVERVOLT;
    pb = (cur ? IMAX_PH_LO : VMAX_PH_LO) + ph;
    if (cur) samp('0, s);
    else samp(s, '0);
    settle;
    chk_irq(1'b0);
    rdc(ADDR_EVT_STATUS, 32'h1 << b);
    rdc(ADDR_PH_STATUS, 32'h1 << pb);
    u_host.wr(ADDR_EVT_STATUS, 32'h1 << b);
    rdc(ADDR_PH_STATUS, 32'h0);
    settle;
    chk_irq(1'b1);
  endtask : lvl
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : final_report
  // Hang guard
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      final_report;
    end
  end
  initial begin
    {mclk, rst, rd_pend} = 3'h2;
    {cyc, err_total, cmp_count} = '0;
    {smp, zero_cross} = '0;
    r = 24'($urandom(17813));
    repeat (20) @(posedge mclk);
    #1;
    rst = 0;
    rdc(ADDR_OVERVOLT, 32'(FULL_SCALE));
    rdc(ADDR_OVERCUR, 32'(FULL_SCALE));
    rdc(16'h0000, 32'h0);
    r = 24'($urandom);
    u_host.wr(ADDR_SAG, {8'hff, r});
    rdc(ADDR_SAG, {8'h00, r});
    u_host.wr(ADDR_EVT_ENABLE, 32'h0186_0000);
    rdc(ADDR_EVT_ENABLE, 32'h0186_0000);
    for (int i = 0; i < 3; i++) begin
      r = 24'($urandom_range(24'h3fffff, 1));
      u_host.wr(ADDR_OVERVOLT, {8'h00, r});
      u_host.wr(ADDR_OVERCUR, {8'h00, r});
      samp({3{-r}}, {3{-r}});
      settle;
      chk_irq(1'b1);
      lvl(0, i, r + 24'h1);
      lvl(1, i, r + 24'h1);
    end
    u_host.wr(ADDR_OVERVOLT, 32'h0);
    samp('0, '0);
    settle;
    chk_irq(1'b0);
    rdc(ADDR_PH_STATUS, 32'h0000_0e00);
    u_host.wr(ADDR_OVERVOLT, 32'(FULL_SCALE));
    u_host.wr(ADDR_OVERCUR, 32'(FULL_SCALE));
    u_host.wr(ADDR_EVT_STATUS, 32'h0004_0000);
    samp({3{-FULL_SCALE}}, {3{-FULL_SCALE}});
    settle;
    chk_irq(1'b1);
    u_host.wr(ADDR_SAG, 32'h1);
    samp('0, '0);
    settle;
    chk_sag(3'h0);
    u_host.wr(ADDR_SAG, 32'(FULL_SCALE));
    samp({3{-24'h100}}, '0);
    settle;
    chk_sag(3'h7);
    u_host.wr(ADDR_MODE, 32'h0c);
    u_host.wr(ADDR_PEAK_WIN, 32'h2);
    rdc(ADDR_MODE, 32'h0000_000c);
    rdc(ADDR_PEAK_WIN, 32'h0000_0002);
    samp({24'h0, 24'h0, 24'h3000}, {24'h7000, -24'h2000, 24'h1000});
    zc(3'h1);
    zc(3'h4);
    zc(3'h2);
    settle;
    chk_irq(1'b0);
    rdc(ADDR_CUR_PEAK, 32'h0200_2000);
    rdc(ADDR_VOLT_PEAK, 32'h0100_3000);
    rdc(ADDR_EVT_STATUS, 32'h0180_0000);
    samp('0, {24'h0, 24'h0, 24'h0500});
    zc(3'h1);
    rdc(ADDR_CUR_PEAK, 32'h0200_2000);
    zc(3'h2);
    rdc(ADDR_CUR_PEAK, 32'h0100_0500);
    u_host.wr(ADDR_EVT_STATUS, 32'h0180_0000);
    settle;
    chk_irq(1'b1);
    zc(3'h1);
    u_host.wr(ADDR_PEAK_WIN, 32'h2);
    zc(3'h1);
    settle;
    chk_irq(1'b1);
    zc(3'h2);
    settle;
    chk_irq(1'b0);
    // Phase C alone; crossings on A and B must not count
    u_host.wr(ADDR_EVT_STATUS, 32'h0180_0000);
    u_host.wr(ADDR_MODE, 32'h10);
    u_host.wr(ADDR_PEAK_WIN, 32'h1);
    samp('0, {24'h4000, 24'h0, 24'h7000});
    zc(3'h3);
    settle;
    chk_irq(1'b1);
    zc(3'h4);
    rdc(ADDR_CUR_PEAK, 32'h0400_4000);
    settle;
    chk_irq(1'b0);
    // Mid-run reset; status, mode and current peak record read back at their defaults
    rst = 1;
    repeat (2) @(posedge mclk);
    #1;
    rst = 0;
    chk_irq(1'b1);
    rdc(ADDR_EVT_STATUS, 32'h0);
    rdc(ADDR_MODE, 32'h0);
    rdc(ADDR_CUR_PEAK, 32'h0);
    settle;
    final_report;
  end
endmodule : tb_peak_and_level_event_detector
